/* File: meas_ctrl_i2c_regs.v */
// meas_ctrl_i2c_regs.v: measurement and output control register bank behind
// an I2C target port, with its own byte engine and read-back multiplexer.
// assumes pins arrive asynchronously; converter, averager, alarm and
// temperature logic sit on mclk_in; only converter and temperature results come with strobes.
`timescale 1ns/1ps
`default_nettype none
`include "meas_ctrl_defs.vh"

module meas_ctrl_i2c_regs (
   input wire mclk_in,
   input wire reset_in,
   input wire scl_in,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe_out,
   input wire conv_ack_in,
   input wire conv_done_in,
   input wire [12:0] conv_data_in,
   output wire conv_req_out,
   output reg input_range_select_out,
   output reg [4:0] conv_channel_out,
   output reg [7:0] cur_avg_control_out,
   output reg [1:0] cur_avg_channel_out,
   input wire [9:0] cur_avg_result_in,
   output reg [3:0] alarm_view_select_out,
   input wire [7:0] alarm_view_record_in,
   output reg [3:0] high_side_driver_outputs_out,
   output reg [1:0] gpio_drive_out,
   input wire temp_update_in,
   input wire [7:0] temp1_high_in,
   input wire [2:0] temp1_low_in,
   input wire [7:0] temp2_high_in,
   input wire [2:0] temp2_low_in,
   input wire [7:0] temp_int_high_in,
   input wire [2:0] temp_int_low_in,
   input wire [2:0] temp_status_first_in,
   input wire [2:0] temp_status_second_in
);
   // ==========================================================
   // byte engine states
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_ADDR = 3'h1;
   localparam [2:0] S_INSTR = 3'h2;
   localparam [2:0] S_REG = 3'h3;
   localparam [2:0] S_WDATA = 3'h4;
   localparam [2:0] S_READ = 3'h5;
   localparam [2:0] S_WAIT = 3'h6;

   wire scl_rise;
   wire scl_fall;
   wire bus_start;
   wire bus_stop;
   wire sda_level;
   wire conv_pending;
   wire conv_active;
   wire conv_done;
   wire [12:0] conv_result;

   reg [2:0] state_reg;
   reg [3:0] bit_cnt_reg;
   reg [7:0] shift_reg;
   reg [7:0] instr_reg;
   reg [7:0] ptr_reg;
   reg [3:0] sent_cnt_reg;
   reg ack_ok_reg;
   reg wr_en_reg;
   reg [7:0] wr_data_reg;

   reg [7:0] conv_input_select_reg;
   reg [7:0] cur_avg_control_reg;
   reg [7:0] cur_avg_channel_reg;
   reg [7:0] alarm_view_select_reg;
   reg [7:0] output_drive_control_reg;
   reg [9:0] cur_avg_result_reg;
   reg [7:0] alarm_view_record_reg;
   reg [7:0] temp_high_reg [0:2];
   reg [2:0] temp_low_reg [0:2];
   reg [2:0] temp_status_first_reg;
   reg [2:0] temp_status_second_reg;
   reg conv_request_reg;

   i2c_line_sync u_sync (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .scl_rise_out(scl_rise),
      .scl_fall_out(scl_fall),
      .start_out(bus_start),
      .stop_out(bus_stop),
      .sda_level_out(sda_level)
   );

   conv_status_tracker u_conv (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .request_in(conv_request_reg),
      .conv_ack_in(conv_ack_in),
      .conv_done_in(conv_done_in),
      .conv_data_in(conv_data_in),
      .conv_req_out(conv_req_out),
      .pending_out(conv_pending),
      .active_out(conv_active),
      .done_out(conv_done),
      .result_out(conv_result)
   );

   // ==========================================================
   // read-back multiplexer
   // own 8-bit space
   function [7:0] read_mux;
      input [7:0] addr;
      begin
         case (addr)
            `OFS_CONV_INPUT_SELECT: read_mux = conv_input_select_reg;
            `OFS_CONV_RESULT_LOW: read_mux = {conv_result[4:0], conv_pending, conv_active, conv_done};
            `OFS_CONV_RESULT_HIGH: read_mux = conv_result[12:5];
            `OFS_CUR_AVG_CONTROL: read_mux = cur_avg_control_reg;
            `OFS_CUR_AVG_CHANNEL: read_mux = cur_avg_channel_reg;
            `OFS_CUR_AVG_RESULT_LOW: read_mux = cur_avg_result_reg[7:0];
            `OFS_CUR_AVG_RESULT_HIGH: read_mux = {6'h00, cur_avg_result_reg[9:8]};
            `OFS_ALARM_VIEW_SELECT: read_mux = alarm_view_select_reg;
            `OFS_ALARM_VIEW_RECORD: read_mux = alarm_view_record_reg;
            `OFS_OUTPUT_DRIVE: read_mux = output_drive_control_reg;
            `OFS_TEMP1_HIGH: read_mux = temp_high_reg[0];
            `OFS_TEMP1_LOW: read_mux = {temp_low_reg[0], 5'h00};
            `OFS_TEMP2_HIGH: read_mux = temp_high_reg[1];
            `OFS_TEMP2_LOW: read_mux = {temp_low_reg[1], 5'h00};
            `OFS_TEMP_INT_HIGH: read_mux = temp_high_reg[2];
            `OFS_TEMP_INT_LOW: read_mux = {temp_low_reg[2], 5'h00};
            `OFS_TEMP_STATUS_FIRST: read_mux = {5'h00, temp_status_first_reg};
            `OFS_TEMP_STATUS_SECOND: read_mux = {5'h00, temp_status_second_reg};
            default: read_mux = `RESET_ZERO;
         endcase
      end
   endfunction

   // ==========================================================
   // I2C byte engine
   // bit_cnt 0..7 data bits, 8 = ack slot, 9 = ack held until next fall
   always @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         state_reg <= S_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         instr_reg <= 8'h00;
         ptr_reg <= 8'h00;
         sent_cnt_reg <= 4'h0;
         wr_en_reg <= 1'b0;
         wr_data_reg <= 8'h00;
         sda_oe_out <= 1'b0;
         sda_out <= 1'b0;
      end else begin
         wr_en_reg <= 1'b0;
         if (bus_start) begin
            // a repeated start keeps the instruction and pointer
            state_reg <= S_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_oe_out <= 1'b0;
         end else if (bus_stop) begin
            state_reg <= S_IDLE;
            instr_reg <= 8'h00;
            sda_oe_out <= 1'b0;
         end else begin
            case (state_reg)
               S_ADDR, S_INSTR, S_REG, S_WDATA: begin
                  if (scl_rise && bit_cnt_reg < 4'h8) begin
                     shift_reg <= {shift_reg[6:0], sda_level};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                     if (ack_ok_reg) begin
                        sda_oe_out <= 1'b1;
                        bit_cnt_reg <= 4'h9;
                     end else begin
                        state_reg <= S_WAIT;
                     end
                  end else if (scl_fall && bit_cnt_reg == 4'h9) begin
                     sda_oe_out <= 1'b0;
                     bit_cnt_reg <= 4'h0;
                     case (state_reg)
                        S_ADDR: begin
                           if (shift_reg[0]) begin
                              // first read byte driven at once
                              state_reg <= S_READ;
                              shift_reg <= read_mux(ptr_reg);
                              // pull low when the first bit is zero
                              sda_oe_out <= (read_mux(ptr_reg) < 8'h80);
                              sent_cnt_reg <= 4'h1;
                           end else begin
                              state_reg <= S_INSTR;
                           end
                        end
                        S_INSTR: begin
                           instr_reg <= shift_reg;
                           state_reg <= S_REG;
                        end
                        S_REG: begin
                           ptr_reg <= shift_reg;
                           state_reg <= (instr_reg == `INSTR_WRITE_REG) ? S_WDATA : S_WAIT;
                        end
                        default: begin
                           wr_en_reg <= 1'b1;
                           wr_data_reg <= shift_reg;
                           state_reg <= S_WAIT;
                        end
                     endcase
                  end
               end
               S_READ: begin
                  if (scl_rise && bit_cnt_reg < 4'h8) begin
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (scl_fall && bit_cnt_reg < 4'h8 && bit_cnt_reg != 4'h0) begin
                     shift_reg <= {shift_reg[6:0], 1'b0};
                     sda_oe_out <= ~shift_reg[6];
                  end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                     // release for the host's acknowledge
                     sda_oe_out <= 1'b0;
                  end else if (scl_rise && bit_cnt_reg == 4'h8) begin
                     // continue only on ack and below ten bytes
                     // a host nack ends our driving
                     if (!sda_level && sent_cnt_reg < `READ_BYTES_MAX) begin
                        bit_cnt_reg <= 4'h9;
                        ptr_reg <= ptr_reg + 8'h01;
                     end else begin
                        state_reg <= S_WAIT;
                     end
                  end else if (scl_fall && bit_cnt_reg == 4'h9) begin
                     shift_reg <= read_mux(ptr_reg);
                     sda_oe_out <= (read_mux(ptr_reg) < 8'h80);
                     sent_cnt_reg <= sent_cnt_reg + 4'h1;
                     bit_cnt_reg <= 4'h0;
                  end
               end
               default: begin
                  sda_oe_out <= 1'b0;
               end
            endcase
         end
      end
   end

   reg ack_ok_next;

   // ack decision for the byte about to be acknowledged
   always @(*) begin
      case (state_reg)
         S_ADDR: ack_ok_next = (shift_reg[7:1] == `TARGET_ADDR) &&
                               (!shift_reg[0] || instr_reg == `INSTR_READ_REG);
         // other codes belong to the configuration space
         S_INSTR: ack_ok_next = (shift_reg == `INSTR_WRITE_REG) || (shift_reg == `INSTR_READ_REG);
         S_REG, S_WDATA: ack_ok_next = 1'b1;
         default: ack_ok_next = 1'b0;
      endcase
   end
   always @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         ack_ok_reg <= 1'b0;
      end else begin
         ack_ok_reg <= ack_ok_next;
      end
   end

   // ==========================================================
   // writable registers and captured inputs
   genvar t;
   generate
      for (t = 0; t < 3; t = t + 1) begin : g_temp
         always @(posedge mclk_in or posedge reset_in) begin
            if (reset_in) begin
               temp_high_reg[t] <= `RESET_TEMP_HIGH;
               temp_low_reg[t] <= 3'h0;
            end else if (temp_update_in) begin
               temp_high_reg[t] <= (t == 0) ? temp1_high_in : (t == 1) ? temp2_high_in : temp_int_high_in;
               temp_low_reg[t] <= (t == 0) ? temp1_low_in : (t == 1) ? temp2_low_in : temp_int_low_in;
            end
         end
      end
   endgenerate

   always @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         conv_input_select_reg <= `RESET_ZERO;
         cur_avg_control_reg <= `RESET_ZERO;
         cur_avg_channel_reg <= `RESET_ZERO;
         alarm_view_select_reg <= `RESET_ZERO;
         output_drive_control_reg <= `RESET_ZERO;
         cur_avg_result_reg <= 10'h000;
         alarm_view_record_reg <= `RESET_ZERO;
         temp_status_first_reg <= 3'h0;
         temp_status_second_reg <= 3'h0;
         conv_request_reg <= 1'b0;
      end else begin
         conv_request_reg <= 1'b0;
         cur_avg_result_reg <= cur_avg_result_in;
         alarm_view_record_reg <= alarm_view_record_in;
         temp_status_first_reg <= temp_status_first_in;
         temp_status_second_reg <= temp_status_second_in;
         if (wr_en_reg) begin
            case (ptr_reg)
               `OFS_CONV_INPUT_SELECT: begin
                  conv_input_select_reg <= wr_data_reg & `CONV_INPUT_MASK;
                  conv_request_reg <= 1'b1;
               end
               `OFS_CUR_AVG_CONTROL: cur_avg_control_reg <= wr_data_reg & `CUR_AVG_CONTROL_MASK;
               `OFS_CUR_AVG_CHANNEL: cur_avg_channel_reg <= wr_data_reg & `CUR_AVG_CHANNEL_MASK;
               `OFS_ALARM_VIEW_SELECT: alarm_view_select_reg <= wr_data_reg & `ALARM_VIEW_MASK;
               `OFS_OUTPUT_DRIVE: output_drive_control_reg <= wr_data_reg & `OUTPUT_DRIVE_MASK;
               default: conv_request_reg <= 1'b0;
            endcase
         end
      end
   end

   // ==========================================================
   // registered outputs, one cycle behind the register bank
   always @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         input_range_select_out <= 1'b0;
         conv_channel_out <= 5'h00;
         cur_avg_control_out <= `RESET_ZERO;
         cur_avg_channel_out <= 2'h0;
         alarm_view_select_out <= 4'h0;
         high_side_driver_outputs_out <= 4'h0;
         gpio_drive_out <= 2'h0;
      end else begin
         input_range_select_out <= conv_input_select_reg[`RANGE_SELECT_BIT];
         conv_channel_out <= conv_input_select_reg[4:0];
         cur_avg_control_out <= cur_avg_control_reg;
         cur_avg_channel_out <= cur_avg_channel_reg[1:0];
         alarm_view_select_out <= alarm_view_select_reg[3:0];
         high_side_driver_outputs_out <= output_drive_control_reg[3:0];
         gpio_drive_out <= output_drive_control_reg[5:4];
      end
   end
endmodule // meas_ctrl_i2c_regs

`default_nettype wire

/* File: meas_ctrl_defs.vh */
// meas_ctrl_defs.vh: offsets, reset values, masks, instruction codes and
// the target address and read byte limit shared by the measurement/control register bank files.
// assumes inclusion by bare name from the design files.
`ifndef MEAS_CTRL_DEFS_VH
`define MEAS_CTRL_DEFS_VH

// ==========================================================
// instruction codes
`define INSTR_WRITE_REG 8'h51
`define INSTR_READ_REG 8'h52
// target address, value arbitrary
`define TARGET_ADDR 7'h60
// first byte plus up to nine more
`define READ_BYTES_MAX 4'h0a

// ==========================================================
// register offsets
`define OFS_CONV_INPUT_SELECT 8'h00
`define OFS_CONV_RESULT_LOW 8'h01
`define OFS_CONV_RESULT_HIGH 8'h02
`define OFS_CUR_AVG_CONTROL 8'h03
`define OFS_CUR_AVG_CHANNEL 8'h04
`define OFS_CUR_AVG_RESULT_LOW 8'h05
`define OFS_CUR_AVG_RESULT_HIGH 8'h06
`define OFS_ALARM_VIEW_SELECT 8'h07
`define OFS_ALARM_VIEW_RECORD 8'h08
`define OFS_OUTPUT_DRIVE 8'h70
`define OFS_TEMP1_HIGH 8'h80
`define OFS_TEMP1_LOW 8'h81
`define OFS_TEMP2_HIGH 8'h82
`define OFS_TEMP2_LOW 8'h83
`define OFS_TEMP_INT_HIGH 8'h84
`define OFS_TEMP_INT_LOW 8'h85
`define OFS_TEMP_STATUS_FIRST 8'h86
`define OFS_TEMP_STATUS_SECOND 8'h87

// ==========================================================
// field positions and writable masks
`define RANGE_SELECT_BIT 7
`define CONV_INPUT_MASK 8'h9f
`define CUR_AVG_CONTROL_MASK 8'h27
`define CUR_AVG_CHANNEL_MASK 8'h03
`define ALARM_VIEW_MASK 8'h0f
`define OUTPUT_DRIVE_MASK 8'h3f

// ==========================================================
// reset values
`define RESET_ZERO 8'h00
`define RESET_TEMP_HIGH 8'he0

`endif

/* File: i2c_line_sync.v */
// i2c_line_sync.v: brings the bus clock and data pins into the core clock
// domain and derives clock edges and start/stop conditions.
// assumes the core clock runs many times faster than the bus clock.
`timescale 1ns/1ps
`default_nettype none

module i2c_line_sync (
   input wire mclk_in,
   input wire reset_in,
   input wire scl_in,
   input wire sda_in,
   output wire scl_rise_out,
   output wire scl_fall_out,
   output wire start_out,
   output wire stop_out,
   output wire sda_level_out
);
   // stage 0 is read only by stage 1; edges come from stages 1 and 2
   reg [2:0] scl_pipe_reg;
   reg [2:0] sda_pipe_reg;

   always @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         scl_pipe_reg <= 3'h7;
         sda_pipe_reg <= 3'h7;
      end else begin
         scl_pipe_reg <= {scl_pipe_reg[1:0], scl_in};
         sda_pipe_reg <= {sda_pipe_reg[1:0], sda_in};
      end
   end

   assign scl_rise_out = scl_pipe_reg[1] & ~scl_pipe_reg[2];
   assign scl_fall_out = ~scl_pipe_reg[1] & scl_pipe_reg[2];
   assign start_out = scl_pipe_reg[1] & scl_pipe_reg[2] & ~sda_pipe_reg[1] & sda_pipe_reg[2];
   assign stop_out = scl_pipe_reg[1] & scl_pipe_reg[2] & sda_pipe_reg[1] & ~sda_pipe_reg[2];
   assign sda_level_out = sda_pipe_reg[1];
endmodule // i2c_line_sync

`default_nettype wire

/* File: conv_status_tracker.v */
// conv_status_tracker.v: conversion request, pending/active/done flags and
// the captured 13-bit converter result.
// assumes the converter is logic on the same clock, acknowledging a request
// with conv_ack_in and finishing with conv_done_in plus its data.
`timescale 1ns/1ps
`default_nettype none

module conv_status_tracker (
   input wire mclk_in,
   input wire reset_in,
   input wire request_in,
   input wire conv_ack_in,
   input wire conv_done_in,
   input wire [12:0] conv_data_in,
   output reg conv_req_out,
   output reg pending_out,
   output reg active_out,
   output reg done_out,
   output reg [12:0] result_out
);
   always @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         conv_req_out <= 1'b0;
         pending_out <= 1'b0;
         active_out <= 1'b0;
         done_out <= 1'b0;
         result_out <= 13'h0000;
      end else if (request_in) begin
         conv_req_out <= 1'b1;
         pending_out <= 1'b1;
         active_out <= 1'b0;
         done_out <= 1'b0;
      end else if (pending_out && conv_ack_in) begin
         conv_req_out <= 1'b0;
         pending_out <= 1'b0;
         active_out <= 1'b1;
         done_out <= 1'b0;
      end else if (active_out && conv_done_in) begin
         result_out <= conv_data_in;
         active_out <= 1'b0;
         done_out <= 1'b1;
      end
   end
endmodule // conv_status_tracker

`default_nettype wire

/* File: meas_ctrl_i2c_regs_assertions.sv */
// checker for the measurement register bank, top-level ports only
// assumes one clock domain with an asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module meas_ctrl_i2c_regs_assertions (
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe_out,
   input wire logic conv_ack_in,
   input wire logic conv_req_out,
   input wire logic input_range_select_out,
   input wire logic [4:0] conv_channel_out,
   input wire logic [7:0] cur_avg_control_out,
   input wire logic [1:0] cur_avg_channel_out,
   input wire logic [3:0] alarm_view_select_out,
   input wire logic [3:0] high_side_driver_outputs_out,
   input wire logic [1:0] gpio_drive_out
);
   logic [25:0] outs;
   assign outs = {input_range_select_out, conv_channel_out, cur_avg_control_out, cur_avg_channel_out,
      alarm_view_select_out, high_side_driver_outputs_out, gpio_drive_out};
   default clocking @(posedge mclk_in); endclocking
   default disable iff (reset_in);
   // ==========================================================
   // bus pin and register outputs
   a_pin_after_fall: assert property ($changed(sda_oe_out) |-> !scl_in && $past(scl_in, 4))
      else $error("data pin moved outside the low clock phase");
   a_pin_low_only: assert property (sda_out == 1'b0)
      else $error("data pin driven high");
   a_regs_on_write: assert property ($changed(outs) |-> !scl_in)
      else $error("register output moved outside a write");
   a_reset_clears: assert property (disable iff (1'b0) reset_in |-> outs == '0 && !sda_oe_out && !conv_req_out)
      else $error("output not cleared in reset");
   // ==========================================================
   // conversion request
   a_req_after_write: assert property ($rose(conv_req_out) |-> !scl_in)
      else $error("conversion request without a write");
   a_req_holds: assert property (conv_req_out && !conv_ack_in |=> conv_req_out)
      else $error("request dropped before it was taken");
   a_req_taken: assert property (conv_req_out && conv_ack_in |=> !conv_req_out)
      else $error("request stayed after it was taken");
   a_req_drop_cause: assert property ($fell(conv_req_out) |-> $past(conv_ack_in))
      else $error("request fell with no acknowledge");
endmodule // meas_ctrl_i2c_regs_assertions
`default_nettype wire

/* File: i2c_host_model.sv */
// bus controller model: drives the clock and pulls data low, 160 ns a bit
// assumes a pull-up on data, so a released line reads high
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
   input wire logic mclk_in,
   input wire logic sda_in,
   output var logic scl_out,
   output var logic sda_low_out
);
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   // data only moves a quarter bit after the clock, never with it
   task automatic step(input logic c, input logic l);
      repeat (5) @(posedge mclk_in);
      scl_out <= c;
      sda_low_out <= l;
   endtask
   task automatic start_c();
      step(1'b0, sda_low_out);
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
      step(1'b0, 1'b1);
   endtask
   task automatic stop_c();
      step(1'b0, sda_low_out);
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
   endtask
   task automatic xfer(input logic [8:0] o, output logic [8:0] r);
      for (int i = 8; i >= 0; i--) begin
         step(1'b0, sda_low_out);
         step(1'b0, !o[i]);
         step(1'b1, !o[i]);
         step(1'b1, !o[i]);
         r[i] = sda_in;
      end
   endtask
   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic [8:0] r;
      xfer({8'hff, last}, r);
      d = r[8:1];
   endtask
endmodule // i2c_host_model
`default_nettype wire

/* File: test_meas_ctrl_i2c_regs.sv */
// bench for the measurement register bank: register access over the bus
// assumes the host model and the checker files are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "meas_ctrl_defs.vh"
module test_meas_ctrl_i2c_regs;
   logic mclk_in = 1'b0;
   logic reset_in = 1'b0;
   logic scl_in, host_low, sda_out, sda_oe_out, conv_req_out, input_range_select_out;
   logic conv_ack_in = 1'b0;
   logic conv_done_in = 1'b0;
   logic temp_update_in = 1'b0;
   logic [12:0] conv_data_in = 13'h0000;
   logic [9:0] cur_avg_result_in = 10'h000;
   logic [7:0] alarm_view_record_in = 8'h00;
   logic [7:0] tv = 8'h00;
   logic [2:0] tl = 3'h0;
   logic [2:0] ts = 3'h0;
   logic [4:0] conv_channel_out;
   logic [7:0] cur_avg_control_out;
   logic [1:0] cur_avg_channel_out, gpio_drive_out;
   logic [3:0] alarm_view_select_out, high_side_driver_outputs_out;
   logic [7:0] got [10];
   logic [7:0] exp_q [$];
   int err_count = 0;
   int checks = 0;
   wire logic sda_in;
   assign sda_in = !(host_low || (sda_oe_out && !sda_out));
   always #4 mclk_in = ~mclk_in;
   i2c_host_model host (.mclk_in(mclk_in), .sda_in(sda_in), .scl_out(scl_in), .sda_low_out(host_low));
   meas_ctrl_i2c_regs dut (.mclk_in(mclk_in), .reset_in(reset_in), .scl_in(scl_in), .sda_in(sda_in),
      .sda_out(sda_out), .sda_oe_out(sda_oe_out), .conv_ack_in(conv_ack_in), .conv_done_in(conv_done_in),
      .conv_data_in(conv_data_in), .conv_req_out(conv_req_out), .input_range_select_out(input_range_select_out),
      .conv_channel_out(conv_channel_out), .cur_avg_control_out(cur_avg_control_out),
      .cur_avg_channel_out(cur_avg_channel_out), .cur_avg_result_in(cur_avg_result_in),
      .alarm_view_select_out(alarm_view_select_out), .alarm_view_record_in(alarm_view_record_in),
      .high_side_driver_outputs_out(high_side_driver_outputs_out), .gpio_drive_out(gpio_drive_out),
      .temp_update_in(temp_update_in), .temp1_high_in(tv), .temp1_low_in(tl), .temp2_high_in(tv),
      .temp2_low_in(tl), .temp_int_high_in(tv), .temp_int_low_in(tl), .temp_status_first_in(ts),
      .temp_status_second_in(ts));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic send(input logic [7:0] b);
      logic [8:0] r;
      host.xfer({b, 1'b1}, r);
      chk("byte ack", 8'h00, {7'h00, r[0]});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.start_c();
      send({`TARGET_ADDR, 1'b0});
      send(`INSTR_WRITE_REG);
      send(a);
      send(d);
      host.stop_c();
   endtask
   task automatic rd_chk(input logic [7:0] a, input string n);
      host.start_c();
      send({`TARGET_ADDR, 1'b0});
      send(`INSTR_READ_REG);
      send(a);
      host.start_c();
      send({`TARGET_ADDR, 1'b1});
      foreach (exp_q[i]) host.rd_byte(i == exp_q.size() - 1, got[i]);
      host.stop_c();
      foreach (exp_q[i]) chk(n, exp_q[i], got[i]);
      $display("test %s done", n);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      // a real rising edge, so the asynchronous reset acts before the first clock
      reset_in <= 1'b1;
      repeat (20) @(posedge mclk_in);
      reset_in <= 1'b0;
      repeat (5) @(posedge mclk_in);
      exp_q = '{8'he0, 8'h00, 8'he0, 8'h00, 8'he0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      rd_chk(8'h80, "reset page");
      wr(8'h03, 8'hff);
      wr(8'h04, 8'hff);
      wr(8'h07, 8'hff);
      wr(8'h70, 8'hff);
      wr(8'h02, 8'hff);
      wr(8'h71, 8'hff);
      cur_avg_result_in <= 10'h2a5;
      alarm_view_record_in <= 8'h5a;
      exp_q = '{8'h00, 8'h00, 8'h00, 8'h27, 8'h03, 8'ha5, 8'h02, 8'h0f, 8'h5a};
      rd_chk(8'h00, "low page");
      chk("driver pins", 8'h3f, {gpio_drive_out, high_side_driver_outputs_out});
      chk("select pins", 8'h3f, {cur_avg_channel_out, alarm_view_select_out});
      chk("average control pins", 8'h27, cur_avg_control_out);
      wr(8'h00, 8'hff);
      chk("range pins", 8'h9f, {input_range_select_out, 2'b00, conv_channel_out});
      chk("request pin", 8'h01, {7'h00, conv_req_out});
      exp_q = '{8'h9f, 8'h04, 8'h00};
      rd_chk(8'h00, "pending");
      @(posedge mclk_in) conv_ack_in <= 1'b1;
      @(posedge mclk_in) conv_ack_in <= 1'b0;
      conv_data_in <= 13'h1abc;
      @(posedge mclk_in) chk("request pin", 8'h00, {7'h00, conv_req_out});
      exp_q = '{8'h02, 8'h00};
      rd_chk(8'h01, "active");
      @(posedge mclk_in) conv_done_in <= 1'b1;
      @(posedge mclk_in) conv_done_in <= 1'b0;
      exp_q = '{8'he1, 8'hd5};
      rd_chk(8'h01, "result");
      tv <= 8'hc3;
      tl <= 3'h5;
      ts <= 3'h6;
      @(posedge mclk_in) temp_update_in <= 1'b1;
      @(posedge mclk_in) temp_update_in <= 1'b0;
      exp_q = '{8'hc3, 8'ha0, 8'hc3, 8'ha0, 8'hc3, 8'ha0, 8'h06};
      rd_chk(8'h80, "temps");
      exp_q = '{8'h3f, 8'h00};
      rd_chk(8'h70, "after status");
      complete_run();
   end
   initial begin
      #500000;
      err_count++;
      $display("Error watchdog expected end seen timeout");
      complete_run();
   end
endmodule // test_meas_ctrl_i2c_regs
bind meas_ctrl_i2c_regs meas_ctrl_i2c_regs_assertions chk_i (.mclk_in(mclk_in), .reset_in(reset_in),
   .scl_in(scl_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .conv_ack_in(conv_ack_in),
   .conv_req_out(conv_req_out), .input_range_select_out(input_range_select_out),
   .conv_channel_out(conv_channel_out), .cur_avg_control_out(cur_avg_control_out),
   .cur_avg_channel_out(cur_avg_channel_out), .alarm_view_select_out(alarm_view_select_out),
   .high_side_driver_outputs_out(high_side_driver_outputs_out), .gpio_drive_out(gpio_drive_out));
`default_nettype wire
